// ===== inc/slf_pkg.sv
// constants, types and mode lookups for the serial link framing configuration block
package slf_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [9:0] ADDR_LINK_ENABLE = 10'h200;
    localparam logic [9:0] ADDR_MODE_SELECT = 10'h201;
    localparam logic [9:0] ADDR_FRAMES_M1   = 10'h202;
    localparam logic [9:0] ADDR_MANUAL_SYNC = 10'h203;
    localparam logic [9:0] ADDR_LINK_CTRL   = 10'h204;

    ////////////////////////////////////////////////////////////////////////////////
    // field positions
    localparam int ENABLE_BIT      = 0;
    localparam int MANUAL_BIT      = 0;
    localparam int CTRL_UPPER_BIT  = 4;
    localparam int CTRL_SEL_MSB    = 3;
    localparam int CTRL_SEL_LSB    = 2;
    localparam int CTRL_FORMAT_BIT = 1;
    localparam int CTRL_WHITEN_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic       RST_LINK_ENABLE = 1'h1;
    localparam logic [7:0] RST_MODE_SELECT = 8'h02;
    localparam logic [7:0] RST_FRAMES_M1   = 8'h1F;
    localparam logic       RST_MANUAL_N    = 1'h1;
    localparam logic       RST_UPPER_MAP   = 1'h0;
    localparam logic [1:0] RST_SYNC_SEL    = 2'h0;
    localparam logic       RST_FORMAT      = 1'h1;
    localparam logic       RST_WHITEN      = 1'h1;

    ////////////////////////////////////////////////////////////////////////////////
    // widths, lane maps and mode table
    localparam int          SAMPLE_W       = 12;
    localparam logic [7:0]  LANES_LOWER    = 8'h0F;
    localparam logic [7:0]  LANES_UPPER    = 8'hF0;
    localparam logic [15:0] BLOCK_FRAMES   = 16'h0100;
    localparam logic [7:0]  MODE_66B_FIRST = 8'h1E;

    // sync request source choices
    typedef enum logic [1:0]
    {
        SLF_SYNC_DEDICATED = 2'b00,
        SLF_SYNC_TIMESTAMP = 2'b01,
        SLF_SYNC_SOFTWARE  = 2'b10,
        SLF_SYNC_SPARE     = 2'b11
    } slf_sync_src_type;

    // true when the selected mode runs the 64b/66b link layer
    function automatic logic slf_mode_is_66b(input logic [7:0] mode);
        return (mode >= MODE_66B_FIRST);
    endfunction : slf_mode_is_66b

    // k minus one for a 64b/66b mode, from e and f of that mode
    function automatic logic [7:0] slf_mode_k_m1(input logic [7:0] mode);
        logic [15:0] e;
        logic [15:0] f;
        logic [15:0] k;
        e = 16'h0001;
        f = 16'h0001;
        case (mode[1:0])
            2'h0: f = 16'h0008;
            2'h1: f = 16'h0004;
            2'h2:
            begin
                e = 16'h0002;
                f = 16'h0004;
            end
            default: f = 16'h0002;
        endcase
        k = (BLOCK_FRAMES * e) / f;
        return 8'(k - 16'h0001);
    endfunction : slf_mode_k_m1

endpackage : slf_pkg

// ===== inc/slf_stream_if.sv
// sample stream carrier between the config block and its two-entry buffer
`timescale 1ns/1ps
interface slf_stream_if;
    logic                         valid;
    logic                         ready;
    logic [slf_pkg::SAMPLE_W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : slf_stream_if

// ===== rtl/slf_hold2.sv
// two-entry sample buffer with registered valid and ready
`timescale 1ns/1ps
module slf_hold2
(
    input wire logic clk,           // system clock
    input wire logic rstn,          // async reset, active low
    input wire logic clr,           // synchronous flush
    slf_stream_if.snk up,           // filling side
    slf_stream_if.src dn            // draining side
);

    logic [1:0]                   cnt_ff;
    logic [1:0]                   nxt_cnt;
    logic                         ready_ff;
    logic                         valid_ff;
    logic [slf_pkg::SAMPLE_W-1:0] d0_ff;
    logic [slf_pkg::SAMPLE_W-1:0] d1_ff;
    logic                         push;
    logic                         pop;

    ////////////////////////////////////////////////////////////////////////////////
    // handshakes and occupancy
    assign push     = up.valid & ready_ff;
    assign pop      = valid_ff & dn.ready;
    assign up.ready = ready_ff;
    assign dn.valid = valid_ff;
    assign dn.data  = d0_ff;

    always_comb
    begin
        nxt_cnt = cnt_ff;
        if (clr)
            nxt_cnt = 2'h0;
        else if (push && !pop)
            nxt_cnt = cnt_ff + 2'h1;
        else if (pop && !push)
            nxt_cnt = cnt_ff - 2'h1;
    end

    // count and flags, flags mirror the next count so they stay flops
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_ff   <= 2'h0;
            ready_ff <= 1'b0;
            valid_ff <= 1'b0;
        end
        else
        begin
            cnt_ff   <= nxt_cnt;
            ready_ff <= (nxt_cnt != 2'h2);
            valid_ff <= (nxt_cnt != 2'h0);
        end
    end

    // storage: head entry and overflow entry
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            d0_ff <= '0;
            d1_ff <= '0;
        end
        else
        begin
            if (pop)
                d0_ff <= (cnt_ff == 2'h2) ? d1_ff : up.data;
            else if (push && cnt_ff == 2'h0)
                d0_ff <= up.data;
            if (push && ((cnt_ff == 2'h1 && !pop) || (cnt_ff == 2'h2 && pop)))
                d1_ff <= up.data;
        end
    end

endmodule : slf_hold2

// ===== rtl/slf_link_cfg.sv
// framing and sync configuration registers of the serial transmit link
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps

// How it works
// RULE_01 - multiframe length k is the eight-bit frames field plus one
// RULE_02 - frames field resets to 31, giving 32 frames per multiframe
// RULE_03 - 64b/66b modes ignore the frames field, k comes from the mode
// RULE_04 - in 64b/66b modes k equals 256 times e divided by f
// RULE_05 - software changes frames field and scrambler only while link disabled
// RULE_06 - writing 0 to manual sync bit requests sync like sync pin low
// RULE_07 - manual sync bit at 0 requests sync whatever source is selected
// RULE_08 - a low selected pin holds the request; software source and spare value 3 both release it
// RULE_09 - upper map 0: both links use lanes 0 to 3, rest off
// RULE_10 - upper map 1: both links use lanes 4 to 7, lower off
// RULE_11 - software sets upper map only with modes of at most 8 lanes
// RULE_12 - source field: 0 dedicated pin, 1 timestamp pin, 2 software only
// RULE_13 - timestamp source needs the timestamp receiver enabled by software
// RULE_14 - format bit 0 gives offset binary, 1 two's complement, reset 1
// RULE_15 - in 8b/10b modes scrambler bit 0 disables, 1 enables, reset 1
// RULE_16 - 64b/66b modes always scramble and ignore the scrambler bit
// RULE_17 - link disabled holds link and multiframe counter reset, lanes and clocks off
// RULE_18 - reserved bits ignore writes and read back as zero
module slf_link_cfg
(
    input  wire logic                         clk,                   // system clock
    input  wire logic                         rstn,                  // async reset
    input  wire logic [9:0]                   reg_addr,              // register offset
    input  wire logic [7:0]                   reg_wdata,             // write data
    input  wire logic                         reg_wr,                // write strobe
    input  wire logic                         reg_rd,                // read strobe
    output logic      [7:0]                   reg_rdata,             // read data, next cycle
    input  wire logic                         dedicated_sync_pin_n,  // sync pin, low requests
    input  wire logic                         timestamp_pin_n,       // timestamp pin as sync
    input  wire logic                         frame_tick,            // one pulse per frame
    input  wire logic [slf_pkg::SAMPLE_W-1:0] sample_data,           // two's complement sample
    input  wire logic                         sample_valid,          // sample offered
    output logic                              sample_ready,          // buffer has room
    output logic      [slf_pkg::SAMPLE_W-1:0] lane_data,             // formatted sample
    output logic                              lane_valid,            // formatted sample ready
    input  wire logic                         lane_ready,            // serializer takes it
    output logic                              sync_request,          // link resync request
    output logic      [7:0]                   k_less_one,            // effective k minus one
    output logic                              multiframe_start,      // first frame of multiframe
    output logic                              whitening_active,      // lane scrambling on
    output logic                              link_block_reset_n,    // link block out of reset
    output logic      [7:0]                   lane_a_power,          // link a lane power enables
    output logic      [7:0]                   lane_b_power,          // link b lane power enables
    output logic                              serializer_clk_on      // serializer clock gate
);

    logic                         link_enable_ff;
    logic [7:0]                   mode_ff;
    logic [7:0]                   frames_m1_ff;
    logic                         manual_n_ff;
    logic                         upper_map_ff;
    slf_pkg::slf_sync_src_type    sync_sel_ff;
    logic                         format_ff;
    logic                         whiten_ff;
    logic [7:0]                   rdata_ff;
    logic                         sync_req_ff;
    logic [7:0]                   k_m1_ff;
    logic [7:0]                   mf_cnt_ff;
    logic                         mf_start_ff;
    logic                         whiten_act_ff;
    logic                         link_rst_n_ff;
    logic [7:0]                   lane_a_ff;
    logic [7:0]                   lane_b_ff;
    logic                         ser_clk_ff;
    logic                         mode_66b;
    logic [7:0]                   nxt_k_m1;
    logic                         pin_req;
    logic [7:0]                   nxt_rdata;
    logic                         seen_frames_wr_ff;

    slf_stream_if samp_in ();
    slf_stream_if samp_out ();

    ////////////////////////////////////////////////////////////////////////////////
    // register writes, one process per register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            link_enable_ff <= slf_pkg::RST_LINK_ENABLE;
        else if (reg_wr && reg_addr == slf_pkg::ADDR_LINK_ENABLE)
            link_enable_ff <= reg_wdata[slf_pkg::ENABLE_BIT];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            mode_ff <= slf_pkg::RST_MODE_SELECT;
        else if (reg_wr && reg_addr == slf_pkg::ADDR_MODE_SELECT)
            mode_ff <= reg_wdata;
    end

    // frames field, meant to change only with the link off
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            frames_m1_ff <= slf_pkg::RST_FRAMES_M1;                 // RULE_02
        else if (reg_wr && reg_addr == slf_pkg::ADDR_FRAMES_M1)
            frames_m1_ff <= reg_wdata;                              // RULE_01
    end

    // manual sync bit, reserved bits dropped
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            manual_n_ff <= slf_pkg::RST_MANUAL_N;
        else if (reg_wr && reg_addr == slf_pkg::ADDR_MANUAL_SYNC)
            manual_n_ff <= reg_wdata[slf_pkg::MANUAL_BIT];          // RULE_18
    end

    // link control fields, bits 7:5 not stored
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            upper_map_ff <= slf_pkg::RST_UPPER_MAP;
            sync_sel_ff  <= slf_pkg::slf_sync_src_type'(slf_pkg::RST_SYNC_SEL);
            format_ff    <= slf_pkg::RST_FORMAT;                    // RULE_14
            whiten_ff    <= slf_pkg::RST_WHITEN;                    // RULE_15
        end
        else if (reg_wr && reg_addr == slf_pkg::ADDR_LINK_CTRL)
        begin
            upper_map_ff <= reg_wdata[slf_pkg::CTRL_UPPER_BIT];
            sync_sel_ff  <= slf_pkg::slf_sync_src_type'(
                            reg_wdata[slf_pkg::CTRL_SEL_MSB:slf_pkg::CTRL_SEL_LSB]);
            format_ff    <= reg_wdata[slf_pkg::CTRL_FORMAT_BIT];
            whiten_ff    <= reg_wdata[slf_pkg::CTRL_WHITEN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // register reads, data one cycle after the strobe
    always_comb
    begin
        nxt_rdata = 8'h00;
        if (reg_addr == slf_pkg::ADDR_LINK_ENABLE)
            nxt_rdata = {7'h00, link_enable_ff};
        else if (reg_addr == slf_pkg::ADDR_MODE_SELECT)
            nxt_rdata = mode_ff;
        else if (reg_addr == slf_pkg::ADDR_FRAMES_M1)
            nxt_rdata = frames_m1_ff;
        else if (reg_addr == slf_pkg::ADDR_MANUAL_SYNC)
            nxt_rdata = {7'h00, manual_n_ff};                       // RULE_18
        else if (reg_addr == slf_pkg::ADDR_LINK_CTRL)
            nxt_rdata = {3'h0, upper_map_ff, sync_sel_ff, format_ff, whiten_ff};
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata_ff <= 8'h00;
        else if (reg_rd)
            rdata_ff <= nxt_rdata;
        else
            rdata_ff <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sync request: software bit ors with the selected pin
    always_comb
    begin
        case (sync_sel_ff)
            slf_pkg::SLF_SYNC_DEDICATED: pin_req = ~dedicated_sync_pin_n;   // RULE_12
            slf_pkg::SLF_SYNC_TIMESTAMP: pin_req = ~timestamp_pin_n;        // RULE_13
            default:                     pin_req = 1'b0;                    // RULE_08
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            sync_req_ff <= 1'b0;
        else
            sync_req_ff <= ~manual_n_ff | pin_req;                  // RULE_06 RULE_07
    end

    ////////////////////////////////////////////////////////////////////////////////
    // effective k and scrambling from the mode
    assign mode_66b = slf_pkg::slf_mode_is_66b(mode_ff);
    assign nxt_k_m1 = mode_66b ? slf_pkg::slf_mode_k_m1(mode_ff)   // RULE_03 RULE_04
                               : frames_m1_ff;                      // RULE_01

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            k_m1_ff       <= slf_pkg::RST_FRAMES_M1;
            whiten_act_ff <= slf_pkg::RST_WHITEN;
        end
        else
        begin
            k_m1_ff       <= nxt_k_m1;
            whiten_act_ff <= mode_66b | whiten_ff;                  // RULE_15 RULE_16
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // link enable: block reset, lane power and clock gate
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            link_rst_n_ff <= 1'b0;
            ser_clk_ff    <= 1'b0;
            lane_a_ff     <= 8'h00;
            lane_b_ff     <= 8'h00;
        end
        else
        begin
            link_rst_n_ff <= link_enable_ff;                        // RULE_17
            ser_clk_ff    <= link_enable_ff;
            if (!link_enable_ff)
            begin
                lane_a_ff <= 8'h00;
                lane_b_ff <= 8'h00;
            end
            else if (upper_map_ff)
            begin
                lane_a_ff <= slf_pkg::LANES_UPPER;                  // RULE_10 RULE_11
                lane_b_ff <= slf_pkg::LANES_UPPER;
            end
            else
            begin
                lane_a_ff <= slf_pkg::LANES_LOWER;                  // RULE_09
                lane_b_ff <= slf_pkg::LANES_LOWER;
            end
        end
    end

    // multiframe counter, held at zero while the link is off
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mf_cnt_ff   <= 8'h00;
            mf_start_ff <= 1'b0;
        end
        else if (!link_enable_ff)
        begin
            mf_cnt_ff   <= 8'h00;                                   // RULE_17
            mf_start_ff <= 1'b0;
        end
        else
        begin
            mf_start_ff <= frame_tick && (mf_cnt_ff == 8'h00);
            if (frame_tick)
                mf_cnt_ff <= (mf_cnt_ff == k_m1_ff) ? 8'h00 : mf_cnt_ff + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sample format and buffering toward the lanes
    assign samp_in.valid = sample_valid;
    assign samp_in.data  = format_ff ? sample_data                                  // RULE_14
                         : {~sample_data[slf_pkg::SAMPLE_W-1], sample_data[slf_pkg::SAMPLE_W-2:0]};
    assign samp_out.ready = lane_ready;

    slf_hold2 u_hold
    (
        .clk  (clk),
        .rstn (rstn),
        .clr  (~link_enable_ff),
        .up   (samp_in),
        .dn   (samp_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign reg_rdata          = rdata_ff;
    assign sync_request       = sync_req_ff;
    assign k_less_one         = k_m1_ff;
    assign multiframe_start   = mf_start_ff;
    assign whitening_active   = whiten_act_ff;
    assign link_block_reset_n = link_rst_n_ff;
    assign lane_a_power       = lane_a_ff;
    assign lane_b_power       = lane_b_ff;
    assign serializer_clk_on  = ser_clk_ff;
    assign sample_ready       = samp_in.ready;
    assign lane_data          = samp_out.data;
    assign lane_valid         = samp_out.valid;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            seen_frames_wr_ff <= 1'b0;
        else if (reg_wr && reg_addr == slf_pkg::ADDR_FRAMES_M1)
            seen_frames_wr_ff <= 1'b1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_FRAMES_RESET: assert property ( // RULE_02
        !seen_frames_wr_ff |-> frames_m1_ff == 8'h1F && (nxt_rdata == 8'h1F
            || reg_addr != slf_pkg::ADDR_FRAMES_M1))
        else $error("frames field left its reset value without a write");

    AST_K_FROM_FIELD: assert property ( // RULE_01
        reg_wr && reg_addr == slf_pkg::ADDR_FRAMES_M1 && !mode_66b ##1 !mode_66b
            |=> k_less_one == $past(reg_wdata, 2))
        else $error("k does not follow the frames field");

    AST_K_FROM_MODE: assert property ( // RULE_04
        mode_66b |=> k_less_one == slf_pkg::slf_mode_k_m1($past(mode_ff)))
        else $error("64b/66b k not derived from the mode");

    AST_MF_WRAP: assert property ( // RULE_01
        link_enable_ff && frame_tick && mf_cnt_ff == k_m1_ff ##1 link_enable_ff
            |=> multiframe_start || !$past(frame_tick))
        else $error("multiframe did not restart after k frames");

    AST_MANUAL_SYNC: assert property ( // RULE_07
        !manual_n_ff [*2] |=> sync_request)
        else $error("manual sync bit low without a request");

    AST_SW_RELEASE: assert property ( // RULE_08
        sync_sel_ff == slf_pkg::SLF_SYNC_SOFTWARE && manual_n_ff |=> !sync_request)
        else $error("software source still requests sync");

    AST_PIN_HOLD: assert property ( // RULE_12
        sync_sel_ff == slf_pkg::SLF_SYNC_DEDICATED && !dedicated_sync_pin_n |=> sync_request)
        else $error("low dedicated pin did not request sync");

    AST_LANE_MAP: assert property ( // RULE_10
        link_enable_ff && upper_map_ff |=> lane_a_power == 8'hF0 && lane_b_power == 8'hF0)
        else $error("upper lane map not applied");

    AST_LINK_OFF: assert property ( // RULE_17
        !link_enable_ff ##1 !link_enable_ff |-> !link_block_reset_n && mf_cnt_ff == 8'h00
            && lane_a_power == 8'h00 && !serializer_clk_on && !lane_valid)
        else $error("disabled link not held off");

    AST_WHITEN_66B: assert property ( // RULE_16
        mode_66b |=> whitening_active)
        else $error("64b/66b mode without scrambling");

    AST_RESERVED_ZERO: assert property ( // RULE_18
        reg_rd && reg_addr == slf_pkg::ADDR_LINK_CTRL |=> reg_rdata[7:5] == 3'h0)
        else $error("reserved control bits read nonzero");

endmodule : slf_link_cfg

// ===== dv/slf_rx_model.sv
// far-side lane receiver model: accepts lane words and drives the sync pin
`timescale 1ns/1ps
module slf_rx_model
(
    input  wire logic                         clk,        // system clock
    input  wire logic [slf_pkg::SAMPLE_W-1:0] lane_data,  // word from the block
    input  wire logic                         lane_valid, // word offered
    input  wire logic                         stall,      // bench asks for back-pressure
    input  wire logic                         want_sync,  // bench asks for a resync
    output logic                              lane_ready, // word accepted
    output logic                              sync_n      // sync pin, low requests
);
    logic [slf_pkg::SAMPLE_W-1:0] q[$];
    ////////////////////////////////////////////////////////////////////////////////
    // ready and sync pin follow the bench commands
    assign lane_ready = !stall;
    assign sync_n     = !want_sync;
    // record each accepted word in order
    always @(posedge clk)
        if (lane_valid && lane_ready) q.push_back(lane_data);
endmodule : slf_rx_model

// ===== dv/test_serial_link_framing_config.sv
// bench for the link framing configuration registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module test_serial_link_framing_config;
    typedef struct { logic [7:0] w, rb, ln; logic wh; } slf_row_type;
    logic clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, tsn = 1, tick = 0, s_valid = 0;
    logic stall = 0, want_sync = 0, s_ready, l_valid, l_ready, sync_n, sync_req, mf;
    logic wh, lrst_n, clk_on;
    logic [9:0]  reg_addr = 0;
    logic [7:0]  reg_wdata = 0, rdata, k_m1, pa, pb, v;
    logic [11:0] s_data = 0, l_data;
    int          err_count = 0, total_checks = 0, n;
    slf_row_type rows [4] = '{'{8'h10, 8'h10, 8'hF0, 0}, '{8'hE3, 8'h03, 8'h0F, 1},
                              '{8'h19, 8'h19, 8'hF0, 1}, '{8'h02, 8'h02, 8'h0F, 0}};
    logic [9:0]  ra [6] = '{10'h200, 10'h201, 10'h202, 10'h203, 10'h204, 10'h205};
    logic [7:0]  re [6] = '{8'h01, 8'h02, 8'h1F, 8'h01, 8'h03, 8'h00};
    logic [7:0]  kt [4] = '{8'h1F, 8'h3F, 8'h7F, 8'h7F};
    ////////////////////////////////////////////////////////////////////////////////
    // clock, design and far-side model
    always #5 clk = ~clk;
    slf_link_cfg dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .dedicated_sync_pin_n(sync_n),
        .timestamp_pin_n(tsn), .frame_tick(tick), .sample_data(s_data),
        .sample_valid(s_valid), .sample_ready(s_ready), .lane_data(l_data),
        .lane_valid(l_valid), .lane_ready(l_ready), .sync_request(sync_req),
        .k_less_one(k_m1), .multiframe_start(mf), .whitening_active(wh),
        .link_block_reset_n(lrst_n), .lane_a_power(pa), .lane_b_power(pb),
        .serializer_clk_on(clk_on));
    slf_rx_model rx (.clk(clk), .lane_data(l_data), .lane_valid(l_valid), .stall(stall),
        .want_sync(want_sync), .lane_ready(l_ready), .sync_n(sync_n));
    ////////////////////////////////////////////////////////////////////////////////
    // bus cycles, sample push and verdict
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = rdata;
    endtask : rd
    task automatic idle(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask : idle
    task automatic push(input logic [11:0] d);
        int t;
        t = 0;
        @(posedge clk);
        s_valid <= 1'b1;
        s_data <= d;
        #1;
        while (s_ready !== 1'b1 && t < 20)
        begin
            @(posedge clk);
            #1;
            t++;
        end
        if (t == 20)
            err_count++;
        @(posedge clk);
        s_valid <= 1'b0;
    endtask : push
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : tally_and_finish
    // watchdog against a hung handshake
    initial
    begin
        #50us;
        err_count++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        idle(2);
        for (int i = 0; i < 6; i++)
        begin
            rd(ra[i], v);
            `CHK("reset value", re[i], v)
        end
        `CHK("k reset", 8'h1F, k_m1)
        `CHK("sync idle", 1'b0, sync_req)
        $display("test reset done");
        // ctrl fields written with the link disabled, as software must
        for (int i = 0; i < 4; i++)
        begin
            wr(10'h200, 8'h00);
            wr(10'h204, rows[i].w);
            rd(10'h204, v);
            `CHK("ctrl readback", rows[i].rb, v)
            `CHK("lanes off", 8'h00, pa | pb)
            `CHK("link held", 1'b0, lrst_n | clk_on)
            wr(10'h200, 8'h01);
            idle(2);
            `CHK("link run", 1'b1, lrst_n & clk_on)
            `CHK("lanes a", rows[i].ln, pa)
            `CHK("lanes b", rows[i].ln, pb)
            `CHK("whitening", rows[i].wh, wh)
        end
        $display("test ctrl rows done");
        wr(10'h200, 8'h00);
        wr(10'h202, 8'h07);
        wr(10'h200, 8'h01);
        idle(2);
        `CHK("k field", 8'h07, k_m1)
        for (int m = 0; m < 4; m++)
        begin
            wr(10'h200, 8'h00);
            wr(10'h201, 8'h20 + 8'(m));
            wr(10'h200, 8'h01);
            idle(2);
            `CHK("k block mode", kt[m], k_m1)
            `CHK("whiten forced", 1'b1, wh)
        end
        wr(10'h200, 8'h00);
        wr(10'h201, 8'h02);
        wr(10'h202, 8'h03);
        wr(10'h200, 8'h01);
        idle(2);
        n = 0;
        for (int i = 0; i < 18; i++)
        begin
            @(posedge clk);
            tick <= (i < 8);
            #1;
            n += (mf === 1'b1);
        end
        `CHK("multiframe starts", 2, n)
        $display("test framing done");
        @(posedge clk);
        want_sync <= 1'b1;
        idle(2);
        `CHK("pin sync", 1'b1, sync_req)
        wr(10'h204, 8'h0A);
        idle(2);
        `CHK("pin released", 1'b0, sync_req)
        wr(10'h204, 8'h0E);
        idle(2);
        `CHK("spare released", 1'b0, sync_req)
        wr(10'h203, 8'h00);
        idle(2);
        `CHK("manual sync", 1'b1, sync_req)
        wr(10'h203, 8'h01);
        want_sync <= 1'b0;
        wr(10'h204, 8'h06);
        tsn <= 1'b0;
        idle(2);
        `CHK("timestamp sync", 1'b1, sync_req)
        tsn <= 1'b1;
        idle(2);
        `CHK("timestamp idle", 1'b0, sync_req)
        $display("test sync done");
        @(posedge clk);
        stall <= 1'b1;
        push(12'h800);
        push(12'h7FF);
        idle(1);
        `CHK("buffer full", 1'b0, s_ready)
        @(posedge clk);
        stall <= 1'b0;
        idle(4);
        wr(10'h204, 8'h04);
        idle(2);
        push(12'h800);
        idle(4);
        `CHK("words", 3, rx.q.size())
        `CHK("twos first", 12'h800, rx.q[0])
        `CHK("twos second", 12'h7FF, rx.q[1])
        `CHK("offset binary", 12'h000, rx.q[2])
        $display("test stream done");
        tally_and_finish();
    end
endmodule : test_serial_link_framing_config
